/* rtl/dee_pkg.sv */
/*
  dee_pkg: constants and state types for the data EEPROM access controller.
  Assumes a 50 MHz system clock and an APB register port with word-aligned registers.
*/
package dee_pkg;

  // ==========================================================
  // timing
  localparam int unsigned DEE_CLK_MHZ = 50;
  localparam int unsigned DEE_PROG_TIME_US = 2000;
  localparam int unsigned DEE_PROG_CYCLES = DEE_PROG_TIME_US * DEE_CLK_MHZ;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [11:0] DEE_IDX_CTRL = 12'h760;
  localparam logic [11:0] DEE_IDX_ADDR_LO = 12'h762;
  localparam logic [11:0] DEE_IDX_ADDR_HI = 12'h764;
  localparam logic [11:0] DEE_IDX_KEY = 12'h766;
  localparam logic [11:0] DEE_IDX_DONE = 12'h768;
  localparam logic [15:0] DEE_BA_CTRL = {2'h0, DEE_IDX_CTRL, 2'h0};
  localparam logic [15:0] DEE_BA_ADDR_LO = {2'h0, DEE_IDX_ADDR_LO, 2'h0};
  localparam logic [15:0] DEE_BA_ADDR_HI = {2'h0, DEE_IDX_ADDR_HI, 2'h0};
  localparam logic [15:0] DEE_BA_KEY = {2'h0, DEE_IDX_KEY, 2'h0};
  localparam logic [15:0] DEE_BA_DONE = {2'h0, DEE_IDX_DONE, 2'h0};

  // ==========================================================
  // control register fields and reset values
  localparam int unsigned DEE_WR_BIT = 15;
  localparam int unsigned DEE_WRITE_ENABLE_BIT_BIT = 14;
  localparam int unsigned DEE_WRITE_ERROR_FLAG_BIT = 13;
  localparam int unsigned DEE_DONE_BIT = 0;
  localparam logic [6:0] DEE_PROGOP_RESET = 7'h00;
  localparam logic [15:0] DEE_ADDR_LO_RESET = 16'h0000;
  localparam logic [7:0] DEE_ADDR_HI_RESET = 8'h00;

  // ==========================================================
  // unlock keys and operation codes
  localparam logic [7:0] DEE_KEY_FIRST = 8'h55;
  localparam logic [7:0] DEE_KEY_SECOND = 8'hAA;
  localparam logic [6:0] DEE_OP_ERASE_BLOCK = 7'h45;
  localparam logic [6:0] DEE_OP_ERASE_WORD = 7'h44;
  localparam logic [6:0] DEE_OP_PROG_WORD = 7'h04;
  localparam logic [6:0] DEE_OP_PROG_BLOCK = 7'h0A;

  // ==========================================================
  // array geometry
  localparam logic [11:0] DEE_EE_PAGE = 12'h7FF;
  localparam int unsigned DEE_EE_AW = 11;
  localparam int unsigned DEE_BLOCK_WORDS = 16;
  localparam logic [15:0] DEE_ERASED_WORD = 16'hFFFF;
  localparam logic [15:0] DEE_BUSY_READ_DATA = 16'h0000;

  // ==========================================================
  // state machines
  typedef enum logic [2:0] {
    DEE_KEY_IDLE = 3'b001,
    DEE_KEY_HALF = 3'b010,
    DEE_KEY_ARMED = 3'b100
  } dee_key_t;

  typedef enum logic [1:0] {
    DEE_OP_IDLE = 2'b01,
    DEE_OP_BUSY = 2'b10
  } dee_op_t;

endpackage

/* rtl/dee_ctrl.sv */
/*
  dee_ctrl: data EEPROM access controller with array, write latches, unlock
  sequence and timed erase/program cycle.
  Assumes an APB master on pclk, a CPU table port on pclk, and reset-cause
  notifications (master clear, watchdog) arriving asynchronously.
*/
// Summary of operation
// - word and 16-word block erase/program
// - array at 0x7FF000 to 0x7FFFFE
// - target from low address only, upper unused
// - table read returns addressed word
// - cycle lasts about 2 ms
// - cpu never stalled during cycle
// - reads during cycle return zero
// - start bit set-only, hardware clears
// - write enable reset clear, software only
// - reset abort sets error, address kept
// - completion sets sticky done flag
// - keys 0x55, 0xAA then start
// - enable must precede start write
// - clearing enable never aborts cycle
// - code 0x4045 erases block
// - code 0x4044 erases one word
// - code 0x4004 programs one word
// - table write loads latch, captures address
// - start control is control bit 15
// - key register write-only, reads zero
`timescale 1ns/1ps
`default_nettype none
module dee_ctrl
  import dee_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = DEE_PROG_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tbl_valid,
  input wire logic tbl_write,
  input wire logic [23:0] tbl_addr,
  input wire logic [15:0] tbl_wdata,
  output logic tbl_ack,
  output logic [15:0] tbl_rdata,
  input wire logic master_clear_reset_event,
  input wire logic wdt_event,
  output logic busy,
  output logic program_done_flag
);

  // ==========================================================
  // apb decode
  logic wr_acc, rd_setup, hit_ctrl, hit_lo, hit_hi, hit_key, hit_done, hit_any;
  logic [31:0] prdata_reg;

  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit_ctrl = (paddr == DEE_BA_CTRL);
  assign hit_lo = (paddr == DEE_BA_ADDR_LO);
  assign hit_hi = (paddr == DEE_BA_ADDR_HI);
  assign hit_key = (paddr == DEE_BA_KEY);
  assign hit_done = (paddr == DEE_BA_DONE);
  assign hit_any = hit_ctrl | hit_lo | hit_hi | hit_key | hit_done;
  // zero wait states
  // the cycle runs in the background, so the bus never waits on it
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata = prdata_reg;

  // ==========================================================
  // state declarations
  dee_key_t key_state;
  dee_op_t op_state;
  logic wr_reg;
  logic write_enable_bit_reg;
  logic write_error_flag_reg;
  logic [6:0] progop_reg;
  logic [15:0] addr_lo_reg;
  logic [7:0] addr_hi_reg;
  logic done_reg;
  logic [31:0] op_count_reg;
  logic [6:0] op_code_reg;
  logic [DEE_EE_AW-1:0] tgt_idx_reg;
  logic master_clear_reset_s1, master_clear_reset_s2, wdt_s1, wdt_s2;
  logic abort_s;
  logic op_valid, start_ok, op_finish, op_abort;
  logic tbl_in_range;
  logic [DEE_EE_AW-1:0] tbl_idx;

  // ==========================================================
  // reset-cause synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_clear_reset_s1 <= 1'b0;
      master_clear_reset_s2 <= 1'b0;
      wdt_s1 <= 1'b0;
      wdt_s2 <= 1'b0;
    end else begin
      master_clear_reset_s1 <= master_clear_reset_event;
      master_clear_reset_s2 <= master_clear_reset_s1;
      wdt_s1 <= wdt_event;
      wdt_s2 <= wdt_s1;
    end
  end
  assign abort_s = master_clear_reset_s2 | wdt_s2;

  // ==========================================================
  // start qualification
  // recognised codes
  assign op_valid = (pwdata[6:0] == DEE_OP_ERASE_BLOCK) || (pwdata[6:0] == DEE_OP_ERASE_WORD) ||
                    (pwdata[6:0] == DEE_OP_PROG_WORD) || (pwdata[6:0] == DEE_OP_PROG_BLOCK);
  // start gate
  // write_enable_bit_reg is the value before this write, so setting both at once fails
  assign start_ok = wr_acc & hit_ctrl & pwdata[DEE_WR_BIT] & (key_state == DEE_KEY_ARMED) &
                    write_enable_bit_reg & (op_state == DEE_OP_IDLE) & pwdata[DEE_WRITE_ENABLE_BIT_BIT] & op_valid;
  assign op_finish = (op_state == DEE_OP_BUSY) && (op_count_reg == 32'h0) && !abort_s;
  assign op_abort = (op_state == DEE_OP_BUSY) && abort_s;

  // ==========================================================
  // unlock sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_state <= DEE_KEY_IDLE;
    end else if (wr_acc) begin
      case (key_state)
        DEE_KEY_IDLE: begin
          key_state <= (hit_key && pwdata[7:0] == DEE_KEY_FIRST) ? DEE_KEY_HALF : DEE_KEY_IDLE;
        end
        DEE_KEY_HALF: begin
          key_state <= (hit_key && pwdata[7:0] == DEE_KEY_SECOND) ? DEE_KEY_ARMED : DEE_KEY_IDLE;
        end
        DEE_KEY_ARMED: begin
          key_state <= DEE_KEY_IDLE;
        end
        default: begin
          key_state <= DEE_KEY_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_enable_bit_reg <= 1'b0;
      progop_reg <= DEE_PROGOP_RESET;
    end else if (wr_acc && hit_ctrl) begin
      write_enable_bit_reg <= pwdata[DEE_WRITE_ENABLE_BIT_BIT];
      if (op_state == DEE_OP_IDLE) begin
        progop_reg <= pwdata[6:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_error_flag_reg <= 1'b0;
    end else if (op_abort) begin
      write_error_flag_reg <= 1'b1;
    end else if (wr_acc && hit_ctrl) begin
      write_error_flag_reg <= pwdata[DEE_WRITE_ERROR_FLAG_BIT];
    end
  end

  // ==========================================================
  // operation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_state <= DEE_OP_IDLE;
      wr_reg <= 1'b0;
      op_count_reg <= 32'h0;
      op_code_reg <= DEE_PROGOP_RESET;
      tgt_idx_reg <= '0;
    end else begin
      case (op_state)
        DEE_OP_IDLE: begin
          if (start_ok) begin
            op_state <= DEE_OP_BUSY;
            wr_reg <= 1'b1;
            op_count_reg <= 32'(PROG_CYCLES - 1);
            op_code_reg <= pwdata[6:0];
            tgt_idx_reg <= addr_lo_reg[DEE_EE_AW:1];
          end
        end
        DEE_OP_BUSY: begin
          // only completion or abort ends it
          if (abort_s || op_count_reg == 32'h0) begin
            op_state <= DEE_OP_IDLE;
            wr_reg <= 1'b0;
          end else begin
            op_count_reg <= op_count_reg - 32'h1;
          end
        end
        default: begin
          op_state <= DEE_OP_IDLE;
          wr_reg <= 1'b0;
        end
      endcase
    end
  end
  assign busy = wr_reg;

  // ==========================================================
  // completion flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (op_finish) begin
      done_reg <= 1'b1;
    end else if (wr_acc && hit_done && !pwdata[DEE_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end
  assign program_done_flag = done_reg;

  // ==========================================================
  // address registers
  // only the array window is decoded
  assign tbl_in_range = (tbl_addr[23:12] == DEE_EE_PAGE);
  assign tbl_idx = tbl_addr[DEE_EE_AW:1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_lo_reg <= DEE_ADDR_LO_RESET;
      addr_hi_reg <= DEE_ADDR_HI_RESET;
    end else if (tbl_valid && tbl_in_range) begin
      addr_lo_reg <= tbl_addr[15:0];
      addr_hi_reg <= tbl_addr[23:16];
    end else if (wr_acc && hit_lo) begin
      addr_lo_reg <= pwdata[15:0];
    end else if (wr_acc && hit_hi) begin
      addr_hi_reg <= pwdata[7:0];
    end
  end

  // ==========================================================
  // register read data, sampled in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (rd_setup) begin
      prdata_reg <= 32'h0;
      if (hit_ctrl) begin
        prdata_reg[DEE_WR_BIT] <= wr_reg;
        prdata_reg[DEE_WRITE_ENABLE_BIT_BIT] <= write_enable_bit_reg;
        prdata_reg[DEE_WRITE_ERROR_FLAG_BIT] <= write_error_flag_reg;
        prdata_reg[6:0] <= progop_reg;
      end else if (hit_lo) begin
        prdata_reg[15:0] <= addr_lo_reg;
      end else if (hit_hi) begin
        prdata_reg[7:0] <= addr_hi_reg;
      end else if (hit_done) begin
        prdata_reg[DEE_DONE_BIT] <= done_reg;
      end
    end
  end

  // ==========================================================
  // write latches and array
  logic [15:0] latch_mem [DEE_BLOCK_WORDS];
  logic [15:0] ee_mem [2**DEE_EE_AW];

  for (genvar g = 0; g < DEE_BLOCK_WORDS; g++) begin : g_latch
    always_ff @(posedge pclk) begin
      if (tbl_valid && tbl_write && tbl_in_range && tbl_addr[4:1] == 4'(g)) begin
        latch_mem[g] <= tbl_wdata;
      end
    end
  end

  // array content is non-volatile, so it has no reset
  always_ff @(posedge pclk) begin
    if (op_finish) begin
      case (op_code_reg)
        DEE_OP_ERASE_BLOCK: begin
          for (int j = 0; j < DEE_BLOCK_WORDS; j++) begin
            ee_mem[{tgt_idx_reg[DEE_EE_AW-1:4], 4'(j)}] <= DEE_ERASED_WORD;
          end
        end
        DEE_OP_PROG_BLOCK: begin
          for (int j = 0; j < DEE_BLOCK_WORDS; j++) begin
            ee_mem[{tgt_idx_reg[DEE_EE_AW-1:4], 4'(j)}] <= latch_mem[j];
          end
        end
        DEE_OP_ERASE_WORD: begin
          ee_mem[tgt_idx_reg] <= DEE_ERASED_WORD;
        end
        DEE_OP_PROG_WORD: begin
          ee_mem[tgt_idx_reg] <= latch_mem[tgt_idx_reg[3:0]];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // table port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_ack <= 1'b0;
      tbl_rdata <= 16'h0000;
    end else begin
      tbl_ack <= tbl_valid;
      if (tbl_valid && !tbl_write) begin
        if (!tbl_in_range || op_state == DEE_OP_BUSY) begin
          tbl_rdata <= DEE_BUSY_READ_DATA;
        end else begin
          tbl_rdata <= ee_mem[tbl_idx];
        end
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking dee_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_timer_load;
    start_ok |=> wr_reg && op_count_reg == 32'(PROG_CYCLES - 1);
  endproperty
  a_timer_load: assert property (p_timer_load) else $error("start did not load cycle timer");
  property p_wr_no_clear;
    (op_state == DEE_OP_BUSY) && op_count_reg != 32'h0 && !abort_s && wr_acc && hit_ctrl
      && !pwdata[DEE_WR_BIT] && !pwdata[DEE_WRITE_ENABLE_BIT_BIT] |=> wr_reg;
  endproperty
  a_wr_no_clear: assert property (p_wr_no_clear) else $error("software cleared start bit");
  property p_write_enable_bit_stable;
    !(wr_acc && hit_ctrl) |=> $stable(write_enable_bit_reg);
  endproperty
  a_write_enable_bit_stable: assert property (p_write_enable_bit_stable) else $error("write enable changed by hardware");
  property p_abort;
    op_abort && !tbl_valid && !wr_acc |=> write_error_flag_reg && !wr_reg && !done_reg == !$past(done_reg)
      && addr_lo_reg == $past(addr_lo_reg);
  endproperty
  a_abort: assert property (p_abort) else $error("abort handling wrong");
  property p_done;
    op_finish |=> done_reg && !wr_reg && op_state == DEE_OP_IDLE;
  endproperty
  a_done: assert property (p_done) else $error("completion flag not set");
  property p_no_key;
    wr_acc && hit_ctrl && pwdata[DEE_WR_BIT] && key_state != DEE_KEY_ARMED
      && op_state == DEE_OP_IDLE |=> !wr_reg;
  endproperty
  a_no_key: assert property (p_no_key) else $error("start without unlock");
  property p_same_write;
    wr_acc && hit_ctrl && pwdata[DEE_WR_BIT] && !write_enable_bit_reg && op_state == DEE_OP_IDLE |=> !wr_reg;
  endproperty
  a_same_write: assert property (p_same_write) else $error("start with fresh enable");
  property p_key_discard;
    key_state == DEE_KEY_HALF && wr_acc && !(hit_key && pwdata[7:0] == DEE_KEY_SECOND)
      |=> key_state == DEE_KEY_IDLE;
  endproperty
  a_key_discard: assert property (p_key_discard) else $error("partial unlock kept");
  property p_no_restart;
    op_state == DEE_OP_BUSY && op_count_reg > 32'h1 && !abort_s
      |=> op_count_reg == $past(op_count_reg) - 32'h1;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("cycle restarted or stalled");
  property p_busy_read;
    tbl_valid && !tbl_write && op_state == DEE_OP_BUSY |=> tbl_ack && tbl_rdata == DEE_BUSY_READ_DATA;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy read not masked");
  property p_capture;
    tbl_valid && tbl_in_range |=> {addr_hi_reg, addr_lo_reg} == $past(tbl_addr);
  endproperty
  a_capture: assert property (p_capture) else $error("table address not captured");
  c_start: cover property (start_ok);
  c_finish: cover property (op_finish && op_code_reg == DEE_OP_PROG_WORD);
  c_block_erase: cover property (op_finish && op_code_reg == DEE_OP_ERASE_BLOCK);
  c_abort: cover property (op_abort);

endmodule
`default_nettype wire

/* verif/dee_cpu_model.sv */
/*
  dee_cpu_model: cpu side of the eeprom controller, an apb master and a table port driver.
  assumes one pclk for both ports; the bench calls its tasks and bounds every wait.
*/
`timescale 1ns/1ps
`default_nettype none
module dee_cpu_model
  import dee_pkg::*;
(
  input wire logic pclk,
  input wire logic busy,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic tbl_valid,
  output logic tbl_write,
  output logic [23:0] tbl_addr,
  output logic [15:0] tbl_wdata,
  input wire logic tbl_ack,
  input wire logic [15:0] tbl_rdata
);
  // ==========================================================
  // idle levels
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    tbl_valid = 1'b0;
    tbl_write = 1'b0;
    tbl_addr = 24'h0;
    tbl_wdata = 16'h0;
  end

  // ==========================================================
  // apb transfer, waits on pready with no limit of its own
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data flips so a stale value never looks valid
    pwdata <= ~d;
  endtask

  // ==========================================================
  // table access, answer one cycle after the request
  task automatic tbl(input logic wr, input logic [23:0] a, input logic [15:0] d,
                     output logic [15:0] rd, output logic ack);
    @(posedge pclk);
    tbl_valid <= 1'b1;
    tbl_write <= wr;
    tbl_addr <= a;
    tbl_wdata <= d;
    @(posedge pclk);
    tbl_valid <= 1'b0;
    tbl_wdata <= ~d;
    @(posedge pclk);
    ack = tbl_ack;
    rd = tbl_rdata;
  endtask

  // ==========================================================
  // full start sequence
  task automatic start_op(input logic [15:0] ctrl);
    logic [31:0] r;
    logic e;
    while (busy !== 1'b0) @(posedge pclk);
    apb(1'b1, DEE_BA_CTRL, {16'h0, ctrl}, r, e);
    // keys back to back, nothing in between
    apb(1'b1, DEE_BA_KEY, {24'h0, DEE_KEY_FIRST}, r, e);
    apb(1'b1, DEE_BA_KEY, {24'h0, DEE_KEY_SECOND}, r, e);
    apb(1'b1, DEE_BA_CTRL, {16'h0, ctrl | 16'h8000}, r, e);
  endtask
endmodule
`default_nettype wire

/* verif/dee_ctrl_tb.sv */
/*
  dee_ctrl_tb: self-checking bench for the eeprom controller, shortened cycle time.
  assumes dee_cpu_model drives both bus ports; reset causes come from here.
*/
`timescale 1ns/1ps
`default_nettype none
module dee_ctrl_tb
  import dee_pkg::*;
;
  localparam int PC = 60;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, busy, program_done_flag;
  logic tbl_valid, tbl_write, tbl_ack, master_clear_reset_event, wdt_event;
  logic [15:0] paddr, tbl_wdata, tbl_rdata;
  logic [31:0] pwdata, prdata;
  logic [23:0] tbl_addr;
  int miscompares = 0;
  int cmp_count = 0;
  int blen = 0;
  int last_len = 0;

  // ==========================================================
  // clock, instances, busy length monitor
  always #10 pclk = ~pclk;
  dee_ctrl #(.PROG_CYCLES(PC)) u_dee_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tbl_valid(tbl_valid), .tbl_write(tbl_write),
    .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .tbl_ack(tbl_ack), .tbl_rdata(tbl_rdata),
    .master_clear_reset_event(master_clear_reset_event), .wdt_event(wdt_event), .busy(busy),
    .program_done_flag(program_done_flag));
  dee_cpu_model u_dee_cpu_model (.pclk(pclk), .busy(busy), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tbl_valid(tbl_valid), .tbl_write(tbl_write), .tbl_addr(tbl_addr),
    .tbl_wdata(tbl_wdata), .tbl_ack(tbl_ack), .tbl_rdata(tbl_rdata));
  always @(posedge pclk) begin
    if (busy === 1'b1) begin
      blen <= blen + 1;
    end else if (blen != 0) begin
      last_len <= blen;
      blen <= 0;
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    u_dee_cpu_model.apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] r;
    logic e;
    u_dee_cpu_model.apb(1'b0, a, 32'h0, r, e);
    chk({r[30:0], e}, {exp[30:0], eexp});
  endtask
  task automatic tw(input logic [23:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic k;
    u_dee_cpu_model.tbl(1'b1, a, d, r, k);
  endtask
  task automatic trd(input logic [23:0] a, input logic [15:0] exp);
    logic [15:0] r;
    logic k;
    u_dee_cpu_model.tbl(1'b0, a, 16'h0, r, k);
    chk({15'h0, k, r}, {15'h0, 1'b1, exp});
  endtask
  // cycle end: length, sticky done flag, then software clear
  task automatic op_end();
    repeat (2) @(posedge pclk);
    while (busy !== 1'b0) @(posedge pclk);
    @(posedge pclk);
    chk(32'(last_len), 32'(PC));
    chk({31'h0, program_done_flag}, 32'h1);
    wr(DEE_BA_DONE, 32'h0);
    @(posedge pclk);
    chk({31'h0, program_done_flag}, 32'h0);
  endtask
  task automatic refused(input logic [15:0] pre, input logic keys, input logic stray);
    wr(DEE_BA_CTRL, {16'h0, pre});
    if (keys) wr(DEE_BA_KEY, {24'h0, DEE_KEY_FIRST});
    if (stray) wr(DEE_BA_ADDR_HI, 32'h7F);
    if (keys) wr(DEE_BA_KEY, {24'h0, DEE_KEY_SECOND});
    wr(DEE_BA_CTRL, 32'hC044);
    repeat (2) @(posedge pclk);
    chk({31'h0, busy}, 32'h0);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    wrap_up();
  end

  // ==========================================================
  // scenarios
  initial begin
    presetn = 1'b0;
    master_clear_reset_event = 1'b0;
    wdt_event = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(DEE_BA_CTRL, 32'h0, 1'b0);
    wr(DEE_BA_KEY, 32'h55);
    rdc(DEE_BA_KEY, 32'h0, 1'b0);
    rdc(16'h0004, 32'h0, 1'b1);
    refused(16'h4044, 1'b0, 1'b0);
    refused(16'h0044, 1'b1, 1'b0);
    refused(16'h4044, 1'b1, 1'b1);
    wr(DEE_BA_ADDR_LO, 32'hF020);
    wr(DEE_BA_ADDR_HI, 32'h7F);
    u_dee_cpu_model.start_op(16'h4045);
    op_end();
    for (int i = 0; i < 16; i++) trd(24'h7FF020 + 24'(2 * i), DEE_ERASED_WORD);
    for (int i = 0; i < 16; i++) tw(24'h7FF020 + 24'(2 * i), 16'hA500 + 16'(i));
    rdc(DEE_BA_ADDR_LO, 32'hF03E, 1'b0);
    rdc(DEE_BA_ADDR_HI, 32'h7F, 1'b0);
    u_dee_cpu_model.start_op(16'h400A);
    op_end();
    for (int i = 0; i < 16; i++) trd(24'h7FF020 + 24'(2 * i), 16'hA500 + 16'(i));
    wr(DEE_BA_ADDR_LO, 32'hF024);
    u_dee_cpu_model.start_op(16'h4044);
    op_end();
    trd(24'h7FF024, DEE_ERASED_WORD);
    trd(24'h7FF026, 16'hA502 + 16'h1);
    tw(24'h7FF024, 16'h1234);
    u_dee_cpu_model.start_op(16'h4004);
    op_end();
    trd(24'h7FF024, 16'h1234);
    trd(24'h7FE000, 16'h0000);
    u_dee_cpu_model.start_op(16'h4044);
    repeat (2) @(posedge pclk);
    rdc(DEE_BA_CTRL, 32'hC044, 1'b0);
    wr(DEE_BA_CTRL, 32'h4044);
    wr(DEE_BA_KEY, 32'h55);
    wr(DEE_BA_KEY, 32'hAA);
    wr(DEE_BA_CTRL, 32'hC044);
    wr(DEE_BA_CTRL, 32'h0044);
    trd(24'h7FF026, DEE_BUSY_READ_DATA);
    op_end();
    trd(24'h7FF024, DEE_ERASED_WORD);
    for (int k = 0; k < 2; k++) begin
      u_dee_cpu_model.start_op(16'h4004);
      repeat (5) @(posedge pclk);
      // one pass per reset cause
      master_clear_reset_event <= (k == 0);
      wdt_event <= (k == 1);
      repeat (4) @(posedge pclk);
      master_clear_reset_event <= 1'b0;
      wdt_event <= 1'b0;
      repeat (4) @(posedge pclk);
      chk({30'h0, busy, program_done_flag}, 32'h0);
      rdc(DEE_BA_CTRL, 32'h6004, 1'b0);
      rdc(DEE_BA_ADDR_LO, 32'hF024, 1'b0);
      trd(24'h7FF024, DEE_ERASED_WORD);
      wr(DEE_BA_CTRL, 32'h4004);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
